// ### hdl/alu_flags_map.vh
// register offsets, field positions, reset values and op codes of the alu status block
`ifndef ALU_FLAGS_MAP_VH
`define ALU_FLAGS_MAP_VH
`define ALU_STAT_ADDR      8'h04
`define ALU_CARRY_BIT      0
`define ALU_NIBBLE_BIT     1
`define ALU_ZERO_BIT       2
`define ALU_OVF_BIT        3
`define ALU_P0_LO_BIT      4
`define ALU_P1_LO_BIT      6
`define ALU_MODE_RESET     4'hf
`define ALU_FLAG_RESET     4'h0
`define STEP_DEC           2'h0
`define STEP_INC           2'h1
`define OP_MOVE_W_F        4'h0
`define OP_CLEAR_F         4'h1
`define OP_ADD_F           4'h2
`define OP_ADD_LIT         4'h3
`define OP_SUB_F           4'h4
`define OP_SUB_LIT         4'h5
`define OP_RRC             4'h6
`define OP_RLC             4'h7
`define OP_BIT_CLR         4'h8
`define OP_BIT_SET         4'h9
`define OP_SWAP            4'ha
`define OP_AND             4'hb
`define OP_IOR             4'hc
`define OP_XOR             4'hd
`define OP_INC             4'he
`define OP_DEC             4'hf
`endif

// ### hdl/pointer_step.v
// post-access step of one indirect pointer, selected by a 2-bit mode field
`timescale 1ns/10ps
`default_nettype none
`include "alu_flags_map.vh"
module pointer_step (
   input  wire [1:0] mode,
   input  wire [7:0] ptr_in,
   output reg  [7:0] ptr_out
);
   always @* begin
      case (mode)
         `STEP_DEC: ptr_out = ptr_in - 8'h01;
         `STEP_INC: ptr_out = ptr_in + 8'h01;
         default:   ptr_out = ptr_in;
      endcase
   end
endmodule
`default_nettype wire

// ### hdl/alu_status_flags.v
// 8-bit alu with status flags and indirect pointer mode register
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "alu_flags_map.vh"
// Summary of operation
// - flag-affecting op on status: result not written to flags
// - clear of status: modes zero, zero set
// - subtraction carries act as inverted borrows
// - overflow set outside -128..+127, else cleared
// - overflow means sign bit wrongly changed
// - operands from working, file or immediate
// - bits 7:6 step pointer one
// - bits 5:4 step pointer zero
// - reset: mode bits one, flags undefined (the code loads them with zero)
// - add carry from msb, rotates load carry
module alu_status_flags (
   input  wire       ref_clk,
   input  wire       nrst,
   input  wire       op_valid,
   input  wire [3:0] op_code,
   input  wire [7:0] file_addr,
   input  wire [7:0] file_data,
   input  wire [7:0] literal,
   input  wire [2:0] bit_sel,
   input  wire       dest_is_file,
   input  wire       single_on_w,
   input  wire       ptr0_access,
   input  wire       ptr1_access,
   input  wire [7:0] ptr0_in,
   input  wire [7:0] ptr1_in,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   output reg  [7:0] result,
   output reg        result_to_file,
   output reg  [7:0] working_register,
   output reg  [7:0] ptr0_out,
   output reg  [7:0] ptr1_out,
   output reg        ptr0_load,
   output reg        ptr1_load,
   output wire [7:0] alu_flags_and_pointer_modes
);
   reg  [3:0] mode_r;
   reg  [3:0] flag_r;
   reg  [3:0] mode_nxt;
   reg  [3:0] flag_nxt;
   reg  [7:0] w_nxt;
   reg  [7:0] res;
   reg  [8:0] sum;
   reg  [4:0] nib;
   reg  [7:0] opa;
   reg  [7:0] opb;
   reg  [3:0] upd;
   reg        carry_in;
   reg        arith;
   reg        carry_new;
   reg        nibble_new;
   reg        zero_new;
   reg        ovf_new;
   wire [7:0] step0;
   wire [7:0] step1;
   wire [7:0] src;
   wire       dst_stat;
   wire       stat_wr;
   wire       stat_rd;
   wire [7:0] ptr_in_bus   [0:1];
   wire [7:0] ptr_step_bus [0:1];

   // decoder used only by the status write path, not by the alu
   function is_flag_op;
      input [3:0] op;
      begin
         case (op)
            `OP_MOVE_W_F: is_flag_op = 1'b0;
            `OP_BIT_CLR:  is_flag_op = 1'b0;
            `OP_BIT_SET:  is_flag_op = 1'b0;
            `OP_SWAP:     is_flag_op = 1'b0;
            default:      is_flag_op = 1'b1;
         endcase
      end
   endfunction

   // one address compare shared by the file port and the register port
   function is_stat_addr;
      input [7:0] addr;
      begin
         is_stat_addr = (addr == `ALU_STAT_ADDR);
      end
   endfunction

   assign alu_flags_and_pointer_modes = {mode_r, flag_r};
   // register bus and instruction both may target the status word
   assign dst_stat = op_valid && dest_is_file && is_stat_addr(file_addr);
   // other addresses on the register port are ignored, reads give zero
   assign stat_wr  = reg_wr && is_stat_addr(reg_addr);
   assign stat_rd  = reg_rd && is_stat_addr(reg_addr);
   // status read back through the file port sees the live value
   assign src = (op_valid && is_stat_addr(file_addr)) ? {mode_r, flag_r} :
                (single_on_w ? working_register : file_data);

   // both pointers step alike, one copy per two-bit mode field
   assign ptr_in_bus[0] = ptr0_in;
   assign ptr_in_bus[1] = ptr1_in;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : step_gen
         pointer_step pointer_step_i (
            .mode    (mode_r[2*g+1:2*g]),
            .ptr_in  (ptr_in_bus[g]),
            .ptr_out (ptr_step_bus[g])
         );
      end
   endgenerate

   assign step0 = ptr_step_bus[0];
   assign step1 = ptr_step_bus[1];

   always @* begin
      res      = 8'h00;
      sum      = 9'h000;
      nib      = 5'h00;
      opa      = working_register;
      opb      = src;
      carry_in = 1'b0;
      arith    = 1'b0;
      upd      = 4'h0;
      case (op_code)
         `OP_MOVE_W_F: res = working_register;
         `OP_CLEAR_F: begin
            res = 8'h00;
            upd = 4'b0100;
         end
         `OP_ADD_F, `OP_ADD_LIT, `OP_SUB_F, `OP_SUB_LIT: begin
            // subtract adds the two's complement, so carry out means no borrow
            if (op_code == `OP_ADD_LIT || op_code == `OP_SUB_LIT)
               opb = literal;
            if (op_code == `OP_SUB_F) begin
               opa = src;
               opb = ~working_register;
               carry_in = 1'b1;
            end else if (op_code == `OP_SUB_LIT) begin
               opa = literal;
               opb = ~working_register;
               carry_in = 1'b1;
            end
            sum   = {1'b0, opa} + {1'b0, opb} + {8'h00, carry_in};
            nib   = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, carry_in};
            res   = sum[7:0];
            arith = 1'b1;
            upd   = 4'b1111;
         end
         `OP_INC, `OP_DEC: begin
            // decrement adds all ones, so carry out again means no borrow
            if (op_code == `OP_INC)
               opb = 8'h01;
            else
               opb = 8'hff;
            opa   = src;
            sum   = {1'b0, opa} + {1'b0, opb};
            nib   = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
            res   = sum[7:0];
            arith = 1'b1;
            upd   = 4'b1111;
         end
         `OP_RRC: begin
            res = {flag_r[`ALU_CARRY_BIT], src[7:1]};
            sum = {src[0], 8'h00};
            upd = 4'b0001;
         end
         `OP_RLC: begin
            res = {src[6:0], flag_r[`ALU_CARRY_BIT]};
            sum = {src[7], 8'h00};
            upd = 4'b0001;
         end
         `OP_BIT_CLR: res = src & ~(8'h01 << bit_sel);
         `OP_BIT_SET: res = src | (8'h01 << bit_sel);
         `OP_SWAP:    res = {src[3:0], src[7:4]};
         `OP_AND: begin
            res = working_register & src;
            upd = 4'b0100;
         end
         `OP_IOR: begin
            res = working_register | src;
            upd = 4'b0100;
         end
         `OP_XOR: begin
            res = working_register ^ src;
            upd = 4'b0100;
         end
         default: res = src;
      endcase
   end

   // flag values the current op would give, before the update mask
   always @* begin
      carry_new  = sum[8];
      nibble_new = nib[4];
      zero_new   = (res == 8'h00);
      // sign flips when both inputs agree in sign and the result differs
      ovf_new    = arith && (opa[7] == opb[7]) &&
                   (res[7] != opa[7]);
   end

   always @* begin
      mode_nxt = mode_r;
      flag_nxt = flag_r;
      w_nxt    = working_register;
      if (stat_wr) begin
         mode_nxt = reg_wdata[7:4];
         flag_nxt = reg_wdata[3:0];
      end
      if (op_valid) begin
         if (dst_stat) begin
            mode_nxt = res[7:4];
            // data write to flags only when the op leaves them alone
            if (!is_flag_op(op_code))
               flag_nxt = res[3:0];
         end else if (!dest_is_file)
            w_nxt = res;
         // flag result always wins over the data write
         if (upd[`ALU_CARRY_BIT])
            flag_nxt[`ALU_CARRY_BIT] = carry_new;
         if (upd[`ALU_NIBBLE_BIT])
            flag_nxt[`ALU_NIBBLE_BIT] = nibble_new;
         if (upd[`ALU_ZERO_BIT])
            flag_nxt[`ALU_ZERO_BIT] = zero_new;
         if (upd[`ALU_OVF_BIT])
            flag_nxt[`ALU_OVF_BIT] = ovf_new;
      end
   end

   // status word: op beats register write, settled in the next-state logic
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         mode_r <= `ALU_MODE_RESET;
         // flags have no defined reset; zero keeps simulation free of unknowns
         flag_r <= `ALU_FLAG_RESET;
      end else begin
         mode_r <= mode_nxt;
         flag_r <= flag_nxt;
      end
   end

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         working_register <= 8'h00;
         result           <= 8'h00;
         result_to_file   <= 1'b0;
      end else begin
         working_register <= w_nxt;
         result           <= res;
         // the status word is never handed to the file write port
         result_to_file   <= op_valid && dest_is_file && !dst_stat;
      end
   end

   // read data stands in the cycle after the strobe only
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
      end else if (stat_rd) begin
         reg_rdata <= {mode_r, flag_r};
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // stepped value always offered; the load pulse says whether to take it
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ptr0_out  <= 8'h00;
         ptr1_out  <= 8'h00;
         ptr0_load <= 1'b0;
         ptr1_load <= 1'b0;
      end else begin
         ptr0_out  <= step0;
         ptr1_out  <= step1;
         ptr0_load <= ptr0_access && !mode_r[1];
         ptr1_load <= ptr1_access && !mode_r[3];
      end
   end
endmodule
`default_nettype wire

// ### verification/alu_flags_properties.sv
// port-level assertions of the alu status block
`timescale 1ns/10ps
`default_nettype none
`include "alu_flags_map.vh"
module alu_flags_props (
   input wire       ref_clk,
   input wire       nrst,
   input wire       op_valid,
   input wire [3:0] op_code,
   input wire [7:0] file_addr,
   input wire [7:0] literal,
   input wire       dest_is_file,
   input wire       ptr0_access,
   input wire       ptr1_access,
   input wire [7:0] ptr0_in,
   input wire [7:0] ptr1_in,
   input wire [7:0] result,
   input wire       result_to_file,
   input wire [7:0] working_register,
   input wire [7:0] ptr0_out,
   input wire [7:0] ptr1_out,
   input wire [7:0] alu_flags_and_pointer_modes
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   wire [7:0] st = alu_flags_and_pointer_modes;
   wire [7:0] w = working_register;
   wire [8:0] sum = {1'b0, w} + literal;
   wire [4:0] nib = {1'b0, w[3:0]} + literal[3:0];
   wire       al = op_valid && op_code == `OP_ADD_LIT;
   wire       tgt = op_valid && dest_is_file && file_addr == `ALU_STAT_ADDR;
   property p_clr; tgt && op_code == `OP_CLEAR_F |=> st == {4'h0, $past(st[3]), 1'b1, $past(st[1:0])}; endproperty
   a_clr: assert property (p_clr) else $error("status clear");
   property p_nofile; tgt |=> !result_to_file; endproperty
   a_nofile: assert property (p_nofile) else $error("status written");
   property p_carry; al |=> st[0] == $past(sum[8]) && result == $past(sum[7:0]); endproperty
   a_carry: assert property (p_carry) else $error("add carry");
   property p_nib; al |=> st[1] == $past(nib[4]); endproperty
   a_nib: assert property (p_nib) else $error("nibble carry");
   property p_ovf; al |=> st[3] == ($past(w[7] == literal[7]) && result[7] != $past(w[7])); endproperty
   a_ovf: assert property (p_ovf) else $error("overflow");
   property p_sub; op_valid && op_code == `OP_SUB_LIT |=> st[0] == $past(literal >= w); endproperty
   a_sub: assert property (p_sub) else $error("borrow");
   property p_zero; op_valid && op_code == `OP_AND && !dest_is_file |=> st[2] == (result == 8'h00); endproperty
   a_zero: assert property (p_zero) else $error("zero flag");
   property p_ptr0; ptr0_access && !st[5] |=> ptr0_out == $past(ptr0_in) + ($past(st[4]) ? 8'h01 : 8'hff); endproperty
   a_ptr0: assert property (p_ptr0) else $error("pointer zero step");
   property p_ptr1; ptr1_access && !st[7] |=> ptr1_out == $past(ptr1_in) + ($past(st[6]) ? 8'h01 : 8'hff); endproperty
   a_ptr1: assert property (p_ptr1) else $error("pointer one step");
   // checked during reset itself, so no disable here
   property p_rst; disable iff (1'b0) !nrst |=> st[7:4] == 4'hf; endproperty
   a_rst: assert property (p_rst) else $error("mode reset");
   c_clr: cover property (tgt && op_code == `OP_CLEAR_F);
   c_add: cover property (al);
   c_ptr: cover property (ptr0_access && ptr1_access);
endmodule
bind alu_status_flags alu_flags_props alu_flags_props_i (.*);
`default_nettype wire

// ### verification/alu_status_flags_tb.sv
// self-checking bench of the alu status block
`timescale 1ns/10ps
`default_nettype none
`include "alu_flags_map.vh"
module alu_status_flags_tb;
   logic       ref_clk = '0, nrst = '0, op_valid = '0, dest_is_file = '0, single_on_w = '0;
   logic       ptr0_access = '0, ptr1_access = '0, reg_wr = '0, reg_rd = '0;
   logic [3:0] op_code = '0;
   logic [2:0] bit_sel = '0;
   logic [7:0] file_addr = '0, file_data = '0, literal = '0, ptr0_in = '0, ptr1_in = '0;
   logic [7:0] reg_addr = '0, reg_wdata = '0;
   wire  [7:0] reg_rdata, result, working_register, ptr0_out, ptr1_out;
   wire  [7:0] alu_flags_and_pointer_modes;
   wire        result_to_file, ptr0_load, ptr1_load;
   int         error_cnt = 0, checks_done = 0, cyc = 0;
   alu_status_flags alu_status_flags_i (
      .ref_clk                     (ref_clk),
      .nrst                        (nrst),
      .op_valid                    (op_valid),
      .op_code                     (op_code),
      .file_addr                   (file_addr),
      .file_data                   (file_data),
      .literal                     (literal),
      .bit_sel                     (bit_sel),
      .dest_is_file                (dest_is_file),
      .single_on_w                 (single_on_w),
      .ptr0_access                 (ptr0_access),
      .ptr1_access                 (ptr1_access),
      .ptr0_in                     (ptr0_in),
      .ptr1_in                     (ptr1_in),
      .reg_addr                    (reg_addr),
      .reg_wdata                   (reg_wdata),
      .reg_wr                      (reg_wr),
      .reg_rd                      (reg_rd),
      .reg_rdata                   (reg_rdata),
      .result                      (result),
      .result_to_file              (result_to_file),
      .working_register            (working_register),
      .ptr0_out                    (ptr0_out),
      .ptr1_out                    (ptr1_out),
      .ptr0_load                   (ptr0_load),
      .ptr1_load                   (ptr1_load),
      .alu_flags_and_pointer_modes (alu_flags_and_pointer_modes)
   );
   always #4 ref_clk = ~ref_clk;
   task check(input logic [7:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   task final_report;
      if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // read compares against d, write stores d
   task bus(input logic w, input logic [7:0] a, d);
      @(posedge ref_clk);
      {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
      @(posedge ref_clk);
      {reg_wr, reg_rd} <= 2'h0;
      #1;
      if (!w) check(reg_rdata, d);
   endtask
   task op(input logic [3:0] c, input logic [7:0] fa, fd, lit, input logic d, s);
      @(posedge ref_clk);
      {op_valid, op_code, file_addr, file_data, literal, dest_is_file, single_on_w} <=
         {1'b1, c, fa, fd, lit, d, s};
      @(posedge ref_clk);
      op_valid <= 1'b0;
      #1;
   endtask
   task ptr(input logic [7:0] m, e0, e1);
      bus(1'b1, `ALU_STAT_ADDR, m);
      @(posedge ref_clk);
      {ptr0_access, ptr1_access, ptr0_in, ptr1_in} <= {2'h3, 8'h20, 8'h20};
      @(posedge ref_clk);
      {ptr0_access, ptr1_access} <= 2'h0;
      #1;
      check(ptr0_out, e0);
      check(ptr1_out, e1);
      check({6'h0, ptr1_load, ptr0_load}, {6'h0, !m[7], !m[5]});
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 2000) begin
         error_cnt++;
         final_report;
      end
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      nrst <= 1'b1;
      bus(1'b0, `ALU_STAT_ADDR, 8'hf0);
      bus(1'b1, `ALU_STAT_ADDR, 8'h5a);
      bus(1'b0, `ALU_STAT_ADDR, 8'h5a);
      bus(1'b1, 8'h05, 8'hff);
      bus(1'b0, 8'h05, 8'h00);
      op(`OP_CLEAR_F, `ALU_STAT_ADDR, 8'h33, 8'h00, 1'b1, 1'b0);
      bus(1'b0, `ALU_STAT_ADDR, 8'h0e);
      op(`OP_ADD_LIT, 8'h10, 8'h00, 8'h7f, 1'b0, 1'b0);
      op(`OP_ADD_LIT, 8'h10, 8'h00, 8'h01, 1'b0, 1'b0);
      bus(1'b0, `ALU_STAT_ADDR, 8'h0a);
      op(`OP_ADD_LIT, 8'h10, 8'h00, 8'h80, 1'b0, 1'b0);
      check(working_register, 8'h00);
      bus(1'b0, `ALU_STAT_ADDR, 8'h0d);
      op(`OP_SUB_LIT, 8'h10, 8'h00, 8'h05, 1'b0, 1'b0);
      bus(1'b0, `ALU_STAT_ADDR, 8'h03);
      op(`OP_SUB_LIT, 8'h10, 8'h00, 8'h03, 1'b0, 1'b0);
      bus(1'b0, `ALU_STAT_ADDR, 8'h00);
      op(`OP_ADD_F, `ALU_STAT_ADDR, 8'hff, 8'h00, 1'b1, 1'b0);
      check({4'h0, alu_flags_and_pointer_modes[3:0]}, 8'h00);
      check({7'h0, result_to_file}, 8'h00);
      op(`OP_AND, 8'h10, 8'h00, 8'h00, 1'b0, 1'b0);
      check({7'h0, alu_flags_and_pointer_modes[2]}, 8'h01);
      // zero minus zero leaves no borrow, so the rotate shifts in a one
      op(`OP_SUB_LIT, 8'h10, 8'h00, 8'h00, 1'b0, 1'b0);
      op(`OP_RLC, 8'h10, 8'h55, 8'h00, 1'b0, 1'b1);
      check(working_register, 8'h01);
      op(`OP_RRC, 8'h10, 8'h81, 8'h00, 1'b0, 1'b0);
      check(working_register, 8'h40);
      check({4'h0, alu_flags_and_pointer_modes[3:0]}, 8'h07);
      ptr(8'h10, 8'h21, 8'h1f);
      ptr(8'h40, 8'h1f, 8'h21);
      ptr(8'ha0, 8'h20, 8'h20);
      bit_sel <= 3'h1;
      op(`OP_BIT_SET, `ALU_STAT_ADDR, 8'h00, 8'h00, 1'b1, 1'b0);
      bus(1'b0, `ALU_STAT_ADDR, 8'ha2);
      op(`OP_SWAP, `ALU_STAT_ADDR, 8'h00, 8'h00, 1'b1, 1'b0);
      bus(1'b0, `ALU_STAT_ADDR, 8'h2a);
      op(`OP_MOVE_W_F, `ALU_STAT_ADDR, 8'h00, 8'h00, 1'b1, 1'b0);
      bus(1'b0, `ALU_STAT_ADDR, 8'h40);
      bit_sel <= 3'h6;
      op(`OP_BIT_CLR, `ALU_STAT_ADDR, 8'h00, 8'h00, 1'b1, 1'b0);
      bus(1'b0, `ALU_STAT_ADDR, 8'h00);
      op(`OP_INC, 8'h10, 8'hff, 8'h00, 1'b0, 1'b0);
      bus(1'b0, `ALU_STAT_ADDR, 8'h07);
      op(`OP_XOR, 8'h10, 8'h0f, 8'h00, 1'b0, 1'b0);
      check(working_register, 8'h0f);
      bus(1'b0, `ALU_STAT_ADDR, 8'h03);
      @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      bus(1'b0, `ALU_STAT_ADDR, 8'hf0);
      final_report;
   end
endmodule
`default_nettype wire
